// >>> core/rmc_consts.vh
// constants for the retimer misc control register pair
// assumes inclusion by bare name from the design files under core/
//
// Overview of operation
// - bit 7 of 09h swaps input main-link lane order; resets to no swap
// - lane swap and polarity bits load from the swap/polarity strap at startup
// - swap, polarity and adaptive select writes are dropped while control strap low
// - bit 6 of 09h inverts input lane polarity, effective only in retimer operation
// - bit 3 of 09h forces lowest-power power-down; clearing resumes normal work
// - bit 2 of 09h low lets sink hot-plug drive automatic power-down
// - bits 1:0 of 09h pick config bus rate 5k/10k/100k/400k, reset 100k
// - bit 7 of 0Ah picks source or sink equalizer centre point
// - bit 6 of 0Ah low forwards sink hot-plug to source hot-plug output
// - bit 5 of 0Ah picks fixed or adaptive equalizer, reset adaptive
// - bit 4 of 0Ah enables the receiver equalizer, reset enabled
// - bit 3 of 0Ah enables the auxiliary bridge, reset enabled
// - bit 2 of 0Ah is a self-clearing write-only strobe reading zero
// - staged lane settings reach the lanes on the strobe, or pass straight through while output enable or hot-plug is low or power-down is forced
// - bits 1:0 of 0Ah pick function mode, reset automatic crossover
// - reserved bits read zero and ignore writes
// - clock ratio flag tells one-tenth or one-fortieth clock to bit rate

`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH

// register offsets
`define RMC_LANE_PWR_OFS      8'h09
`define RMC_EQ_FUNC_OFS       8'h0a

// lane_and_power_control fields
`define RMC_SWAP_BIT          7
`define RMC_POL_BIT           6
`define RMC_FPD_BIT           3
`define RMC_INHIBIT_BIT       2
`define RMC_RATE_HI           1
`define RMC_RATE_LO           0

// equalizer_and_function_control fields
`define RMC_APP_BIT           7
`define RMC_BLOCK_BIT         6
`define RMC_ADA_BIT           5
`define RMC_EQEN_BIT          4
`define RMC_AUX_BIT           3
`define RMC_COMMIT_BIT        2
`define RMC_FMODE_HI          1
`define RMC_FMODE_LO          0

// field reset values
`define RMC_SWAP_RST          1'b0
`define RMC_POL_RST           1'b0
`define RMC_FPD_RST           1'b0
`define RMC_INHIBIT_RST       1'b0
`define RMC_RATE_RST          2'b10
`define RMC_APP_RST           1'b0
`define RMC_BLOCK_RST         1'b0
`define RMC_ADA_RST           1'b1
`define RMC_EQEN_RST          1'b1
`define RMC_AUX_RST           1'b1
`define RMC_FMODE_RST         2'b01

// equalizer start point in half-dB steps
`define RMC_EQ_SRC_R10        5'h0d
`define RMC_EQ_SRC_R40        5'h0f
`define RMC_EQ_SNK_R10        5'h18
`define RMC_EQ_SNK_R40        5'h1a

// timing counts
`define RMC_STRAP_SETTLE_CYC  4

`endif

// >>> core/rmc_pin_sync.v
// three-stage synchroniser for asynchronous pin levels
// assumes one destination clock; a change is accepted once the
// second and third stages agree, filtering single-cycle glitches
`timescale 1ns/1ps
`default_nettype none

module rmc_pin_sync #(
	parameter WIDTH = 4
) (
	input  wire             core_clk_in,
	input  wire             rst_n_in,
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] level_out
);

	genvar gi;

	// one independent chain per bit
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;

			// first stage feeds only the second
			always @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					lvl_q <= 1'b0;
				end else begin
					s1_q <= pin_in[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end

			assign level_out[gi] = lvl_q;
		end
	endgenerate

endmodule // rmc_pin_sync

`default_nettype wire

// >>> core/rmc_misc_ctrl.v
// misc control register pair of the link retimer: lane order and
// polarity, power-down, config bus rate, equalizer and function mode.
// assumes a serial config engine on core_clk_in presenting one-cycle
// byte write and read strobes; strap and hot-plug pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"

module rmc_misc_ctrl #(
	parameter LANE_CFG_W = 16,
	parameter STRAP_WAIT = `RMC_STRAP_SETTLE_CYC
) (
	input  wire                  core_clk_in,
	input  wire                  rst_n_in,
	// byte access from the config engine
	input  wire                  reg_wr_en_in,
	input  wire                  reg_rd_en_in,
	input  wire [7:0]            reg_addr_in,
	input  wire [7:0]            reg_wr_data_in,
	output wire [7:0]            reg_rd_data_out,
	// asynchronous pins
	input  wire                  i2c_ctl_strap_in,
	input  wire                  swap_polarity_strap_in,
	input  wire                  sink_hot_plug_in,
	input  wire                  output_enable_in,
	// same-clock status from the link logic
	input  wire                  retimer_active_in,
	input  wire                  clock_ratio_flag_in,
	input  wire [LANE_CFG_W-1:0] lane_cfg_pending_in,
	// controls toward the lanes
	output wire [LANE_CFG_W-1:0] lane_cfg_active_out,
	output wire                  lane_swap_out,
	output wire                  lane_polarity_out,
	output wire                  forced_power_down_out,
	output wire                  power_down_out,
	output wire [1:0]            config_bus_rate_select_out,
	output wire                  app_mode_sink_out,
	output wire [4:0]            eq_start_level_out,
	output wire                  source_hot_plug_out,
	output wire                  receiver_equalizer_enable_out,
	output wire                  adaptive_equalizer_select_out,
	output wire                  aux_bridge_enable_out,
	output wire [1:0]            function_mode_select_out,
	output wire                  lane_settings_commit_out
);

	// synchronised pin levels
	wire       ctl_strap_lvl;
	wire       swap_strap_lvl;
	wire       hpd_lvl;
	wire       oe_lvl;

	// register fields
	reg        swap_q;
	reg        pol_q;
	reg        fpd_q;
	reg        inhibit_q;
	reg  [1:0] rate_q;
	reg        app_q;
	reg        block_q;
	reg        ada_q;
	reg        eqen_q;
	reg        aux_q;
	reg  [1:0] fmode_q;

	// staged lane settings and their applied copies
	reg        eqen_act_q;
	reg        ada_act_q;
	reg  [LANE_CFG_W-1:0] lane_act_q;
	reg        commit_q;
	reg  [1:0] fmode_act_q;

	// startup strap loading
	reg  [7:0] strap_cnt_q;
	reg        strap_done_q;
	wire       strap_load;

	// read path
	reg  [7:0] rd_data_q;
	reg  [7:0] rd_data_d;

	// output registers
	reg        pd_q;
	reg        src_hpd_q;
	reg        pol_eff_q;
	reg  [4:0] eq_lvl_q;
	reg  [4:0] eq_lvl_d;

	// decoded accesses
	wire       wr_lane_pwr;
	wire       wr_eq_func;
	wire       strap_writes_ok;
	wire       direct_apply;
	wire       pd_now;

	// settle count cut to the counter width on purpose
	localparam [7:0] STRAP_WAIT_B = STRAP_WAIT[7:0];

	// pins cross into the core clock here
	rmc_pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      ({i2c_ctl_strap_in, swap_polarity_strap_in,
		                sink_hot_plug_in, output_enable_in}),
		.level_out   ({ctl_strap_lvl, swap_strap_lvl, hpd_lvl, oe_lvl})
	);

	// address decode for the two owned offsets
	assign wr_lane_pwr = reg_wr_en_in && (reg_addr_in == `RMC_LANE_PWR_OFS);
	assign wr_eq_func  = reg_wr_en_in && (reg_addr_in == `RMC_EQ_FUNC_OFS);

	assign strap_writes_ok = ctl_strap_lvl;

	// startup settle counter; waits out the synchroniser latency
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_cnt_q  <= 8'h00;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == STRAP_WAIT_B) begin
				strap_done_q <= 1'b1;
			end else begin
				strap_cnt_q <= strap_cnt_q + 8'h01;
			end
		end
	end

	// one-cycle load pulse at the end of the settle time
	assign strap_load = !strap_done_q && (strap_cnt_q == STRAP_WAIT_B);

	// lane swap and polarity fields
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			swap_q <= `RMC_SWAP_RST;
			pol_q  <= `RMC_POL_RST;
		end else if (strap_load) begin
			swap_q <= swap_strap_lvl;
			pol_q  <= swap_strap_lvl;
		end else if (wr_lane_pwr && strap_writes_ok) begin
			swap_q <= reg_wr_data_in[`RMC_SWAP_BIT];
			pol_q  <= reg_wr_data_in[`RMC_POL_BIT];
		end
	end

	// power and rate fields of 09h
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fpd_q     <= `RMC_FPD_RST;
			inhibit_q <= `RMC_INHIBIT_RST;
			rate_q    <= `RMC_RATE_RST;
		end else if (wr_lane_pwr) begin
			fpd_q     <= reg_wr_data_in[`RMC_FPD_BIT];
			inhibit_q <= reg_wr_data_in[`RMC_INHIBIT_BIT];
			rate_q    <= reg_wr_data_in[`RMC_RATE_HI:`RMC_RATE_LO];
		end
	end

	// fields of 0Ah; the strobe bit is not stored here
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			app_q   <= `RMC_APP_RST;
			block_q <= `RMC_BLOCK_RST;
			eqen_q  <= `RMC_EQEN_RST;
			aux_q   <= `RMC_AUX_RST;
			fmode_q <= `RMC_FMODE_RST;
		end else if (wr_eq_func) begin
			app_q   <= reg_wr_data_in[`RMC_APP_BIT];
			block_q <= reg_wr_data_in[`RMC_BLOCK_BIT];
			eqen_q  <= reg_wr_data_in[`RMC_EQEN_BIT];
			aux_q   <= reg_wr_data_in[`RMC_AUX_BIT];
			fmode_q <= reg_wr_data_in[`RMC_FMODE_HI:`RMC_FMODE_LO];
		end
	end

	// adaptive select is strap guarded, unlike its neighbours
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ada_q <= `RMC_ADA_RST;
		end else if (wr_eq_func && strap_writes_ok) begin
			ada_q <= reg_wr_data_in[`RMC_ADA_BIT];
		end
	end

	// self-clearing apply strobe, one cycle wide
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			commit_q <= 1'b0;
		end else begin
			commit_q <= wr_eq_func && reg_wr_data_in[`RMC_COMMIT_BIT];
		end
	end

	// power-down term, forced or from missing hot-plug
	assign pd_now = fpd_q || (!inhibit_q && !hpd_lvl);

	// lanes are idle here, so settings may pass straight through
	// a strobe written meanwhile finds the copies already current
	assign direct_apply = !oe_lvl || !hpd_lvl || fpd_q;

	// staged settings move on the strobe or whenever direct_apply holds
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			eqen_act_q <= `RMC_EQEN_RST;
			ada_act_q  <= `RMC_ADA_RST;
			lane_act_q <= {LANE_CFG_W{1'b0}};
		end else if (commit_q || direct_apply) begin
			eqen_act_q <= eqen_q;
			ada_act_q  <= ada_q;
			lane_act_q <= lane_cfg_pending_in;
		end
	end

	// a new mode is adopted only across a power-down
	// switching mid-link would upset the lane state machines
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fmode_act_q <= `RMC_FMODE_RST;
		end else if (pd_q) begin
			fmode_act_q <= fmode_q;
		end
	end

	// registered power and hot-plug outputs
	// power-down holds through reset so lanes wake only once settled
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pd_q      <= 1'b1;
			src_hpd_q <= 1'b0;
			pol_eff_q <= 1'b0;
		end else begin
			pd_q      <= pd_now;
			src_hpd_q <= hpd_lvl && !block_q;
			pol_eff_q <= pol_q && retimer_active_in;
		end
	end

	// equalizer start point from placement and ratio
	// ratio flag selects the lower or upper point
	always @* begin
		eq_lvl_d = `RMC_EQ_SRC_R10;
		case ({app_q, clock_ratio_flag_in})
			2'b00: begin
				eq_lvl_d = `RMC_EQ_SRC_R10;
			end
			2'b01: begin
				eq_lvl_d = `RMC_EQ_SRC_R40;
			end
			2'b10: begin
				eq_lvl_d = `RMC_EQ_SNK_R10;
			end
			2'b11: begin
				eq_lvl_d = `RMC_EQ_SNK_R40;
			end
			default: begin
				eq_lvl_d = `RMC_EQ_SRC_R10;
			end
		endcase
	end

	// equalizer point register
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			eq_lvl_q <= `RMC_EQ_SRC_R10;
		end else begin
			eq_lvl_q <= eq_lvl_d;
		end
	end

	// read mux; other offsets belong to other banks and read zero
	always @* begin
		rd_data_d = 8'h00;
		case (reg_addr_in)
			`RMC_LANE_PWR_OFS: begin
				rd_data_d[`RMC_SWAP_BIT]    = swap_q;
				rd_data_d[`RMC_POL_BIT]     = pol_q;
				rd_data_d[`RMC_FPD_BIT]     = fpd_q;
				rd_data_d[`RMC_INHIBIT_BIT] = inhibit_q;
				rd_data_d[`RMC_RATE_HI:`RMC_RATE_LO] = rate_q;
			end
			`RMC_EQ_FUNC_OFS: begin
				rd_data_d[`RMC_APP_BIT]   = app_q;
				rd_data_d[`RMC_BLOCK_BIT] = block_q;
				rd_data_d[`RMC_ADA_BIT]   = ada_q;
				rd_data_d[`RMC_EQEN_BIT]  = eqen_q;
				rd_data_d[`RMC_AUX_BIT]   = aux_q;
				rd_data_d[`RMC_FMODE_HI:`RMC_FMODE_LO] = fmode_q;
			end
			default: begin
				rd_data_d = 8'h00;
			end
		endcase
	end

	// reserved bits stay zero in the mux above
	// strobe bit is never placed on the read path
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_q <= 8'h00;
		end else if (reg_rd_en_in) begin
			rd_data_q <= rd_data_d;
		end
	end

	// outputs, all from flip-flops
	assign reg_rd_data_out               = rd_data_q;
	assign lane_cfg_active_out           = lane_act_q;
	assign lane_swap_out                 = swap_q;
	assign lane_polarity_out             = pol_eff_q;
	assign forced_power_down_out         = fpd_q;
	assign power_down_out                = pd_q;
	assign config_bus_rate_select_out    = rate_q;
	assign app_mode_sink_out             = app_q;
	assign eq_start_level_out            = eq_lvl_q;
	assign source_hot_plug_out           = src_hpd_q;
	assign receiver_equalizer_enable_out = eqen_act_q;
	assign adaptive_equalizer_select_out = ada_act_q;
	assign aux_bridge_enable_out         = aux_q;
	assign function_mode_select_out      = fmode_act_q;
	assign lane_settings_commit_out      = commit_q;

endmodule // rmc_misc_ctrl

`default_nettype wire

// >>> verification/rmc_host_model.sv
// host model issuing single-byte accesses on the config port
// assumes one clock; strobes change 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
	input  wire logic       core_clk_in,
	input  wire logic [7:0] rd_data_in,
	output var logic        wr_en_out,
	output var logic        rd_en_out,
	output var logic [7:0]  addr_out,
	output var logic [7:0]  wdata_out
);
	// idle bus at time zero
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	// one-cycle strobe; released lines show the inverse, not the old byte
	task wr(input logic [7:0] a, d);
		@(posedge core_clk_in);
		#1;
		wr_en_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(posedge core_clk_in);
		#1;
		wr_en_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		#1;
		rd_en_out = 1'b1;
		addr_out = a;
		@(posedge core_clk_in);
		#1;
		rd_en_out = 1'b0;
		addr_out = ~a;
		d = rd_data_in;
	endtask
	task toggle_pd(input logic [7:0] lp);
		wr(8'h09, lp | 8'h08);
		wr(8'h09, lp);
	endtask
endmodule // rmc_host_model
`default_nettype wire

// >>> verification/rmc_misc_ctrl_chk.sv
// checker for the misc control register pair
// assumes only the ports of rmc_misc_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module rmc_misc_ctrl_chk (
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	input wire logic       reg_wr_en_in,
	input wire logic       reg_rd_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wr_data_in,
	input wire logic [7:0] reg_rd_data_out,
	input wire logic       retimer_active_in,
	input wire logic       clock_ratio_flag_in,
	input wire logic       lane_polarity_out,
	input wire logic       forced_power_down_out,
	input wire logic       power_down_out,
	input wire logic [1:0] config_bus_rate_select_out,
	input wire logic       app_mode_sink_out,
	input wire logic [4:0] eq_start_level_out,
	input wire logic       source_hot_plug_out,
	input wire logic [1:0] function_mode_select_out,
	input wire logic       lane_settings_commit_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire w0a = reg_wr_en_in && reg_addr_in == 8'h0a;
	wire w09 = reg_wr_en_in && reg_addr_in == 8'h09;
	wire rd_other = reg_rd_en_in && reg_addr_in != 8'h09 && reg_addr_in != 8'h0a;
	wire app = app_mode_sink_out;
	wire rat = clock_ratio_flag_in;
	// expected start point from placement and ratio
	wire [4:0] eq_exp = app ? (rat ? `RMC_EQ_SNK_R40 : `RMC_EQ_SNK_R10)
		: (rat ? `RMC_EQ_SRC_R40 : `RMC_EQ_SRC_R10);
	// strobe is a lone pulse caused by a write of one
	commit_pulse_a: assert property (lane_settings_commit_out |=> !lane_settings_commit_out)
		else $error("commit strobe longer than one cycle");
	commit_cause_a: assert property (lane_settings_commit_out |-> $past(w0a && reg_wr_data_in[2]))
		else $error("commit strobe without a write of one");
	commit_read_a: assert property (reg_rd_en_in && reg_addr_in == 8'h0a |=> !reg_rd_data_out[2])
		else $error("commit bit read back as one");
	reserved_read_a: assert property (rd_other |=> reg_rd_data_out == 8'h00)
		else $error("unowned address read nonzero");
	rate_write_a: assert property (w09 |=> config_bus_rate_select_out == $past(reg_wr_data_in[1:0]))
		else $error("rate field not written");
	// power state and hot-plug gating
	fpd_power_a: assert property ($past(forced_power_down_out) && forced_power_down_out |-> power_down_out)
		else $error("forced power-down without power-down");
	hpd_block_a: assert property (w0a && reg_wr_data_in[6] |-> ##2 !source_hot_plug_out)
		else $error("hot-plug forwarded while blocked");
	polarity_gate_a: assert property (lane_polarity_out |-> $past(retimer_active_in))
		else $error("polarity inverted outside retimer");
	fmode_hold_a: assert property (!$past(power_down_out) |-> $stable(function_mode_select_out))
		else $error("function mode changed while powered");
	eq_point_a: assert property ($stable({app, rat}) [*2] |-> eq_start_level_out == eq_exp)
		else $error("equalizer start point wrong");
endmodule // rmc_misc_ctrl_chk
bind rmc_misc_ctrl rmc_misc_ctrl_chk rmc_misc_ctrl_chk_i (.core_clk_in, .rst_n_in, .reg_wr_en_in,
	.reg_rd_en_in, .reg_addr_in, .reg_wr_data_in, .reg_rd_data_out, .retimer_active_in,
	.clock_ratio_flag_in, .lane_polarity_out, .forced_power_down_out, .power_down_out,
	.config_bus_rate_select_out, .app_mode_sink_out, .eq_start_level_out, .source_hot_plug_out,
	.function_mode_select_out, .lane_settings_commit_out);
`default_nettype wire

// >>> verification/test_retimer_misc_control_regs.sv
// self-checking bench for the misc control register pair
// assumes the host model drives the byte port; pins are driven here
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module test_retimer_misc_control_regs;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ctl = 1'b1;
	logic        sps = 1'b0;
	logic        hpd = 1'b0;
	logic        oe = 1'b1;
	logic        rtm = 1'b0;
	logic        ratio = 1'b0;
	logic [15:0] pend = 16'h0000;
	logic [15:0] act;
	logic [7:0]  addr, wdata, rdata, r;
	logic [4:0]  eql;
	logic [1:0]  rate, fm;
	logic        wr_en, rd_en, swp, pol, fpd, pd, app, src, eqen, ada, aux, cmt;
	int          errors = 0;
	int          n_compared = 0;
	// 125 MHz clock
	always #4 clk = ~clk;
	rmc_host_model rmc_host_model_i (.core_clk_in(clk), .rd_data_in(rdata), .wr_en_out(wr_en),
		.rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
	rmc_misc_ctrl rmc_misc_ctrl_i (.core_clk_in(clk), .rst_n_in(rst_n), .reg_wr_en_in(wr_en),
		.reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wr_data_in(wdata), .reg_rd_data_out(rdata),
		.i2c_ctl_strap_in(ctl), .swap_polarity_strap_in(sps), .sink_hot_plug_in(hpd),
		.output_enable_in(oe), .retimer_active_in(rtm), .clock_ratio_flag_in(ratio),
		.lane_cfg_pending_in(pend), .lane_cfg_active_out(act), .lane_swap_out(swp),
		.lane_polarity_out(pol), .forced_power_down_out(fpd), .power_down_out(pd),
		.config_bus_rate_select_out(rate), .app_mode_sink_out(app), .eq_start_level_out(eql),
		.source_hot_plug_out(src), .receiver_equalizer_enable_out(eqen),
		.adaptive_equalizer_select_out(ada), .aux_bridge_enable_out(aux),
		.function_mode_select_out(fm), .lane_settings_commit_out(cmt));
	task chk(input string nm, input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task rchk(input logic [7:0] a, e);
		rmc_host_model_i.rd(a, r);
		chk("read", r, e);
	endtask
	task t_regs;
		rchk(8'h09, 8'h02);
		rchk(8'h0a, 8'h39);
		rchk(8'h20, 8'h00);
		chk("pd", pd, 1'b1);
		chk("ada", ada, 1'b1);
		chk("eqen", eqen, 1'b1);
		rmc_host_model_i.wr(8'h09, 8'hf6);
		rchk(8'h09, 8'hc6);
		chk("swap", swp, 1'b1);
		chk("pol", pol, 1'b0);
		rtm = 1'b1;
		cyc(2);
		chk("pol", pol, 1'b1);
		chk("pd", pd, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rmc_host_model_i.wr(8'h09, {6'b110001, i[1:0]});
			cyc(2);
			chk("rate", rate, i[1:0]);
		end
		$display("test regs done");
	endtask
	task t_strap;
		ctl = 1'b0;
		cyc(8);
		rmc_host_model_i.wr(8'h09, 8'h07);
		rmc_host_model_i.wr(8'h0a, 8'h11);
		cyc(2);
		chk("swap", swp, 1'b1);
		chk("ada", ada, 1'b1);
		chk("aux", aux, 1'b0);
		ctl = 1'b1;
		hpd = 1'b1;
		rmc_host_model_i.wr(8'h0a, 8'h79);
		cyc(8);
		chk("src", src, 1'b0);
		rmc_host_model_i.wr(8'h0a, 8'h39);
		rmc_host_model_i.wr(8'h09, 8'hc2);
		cyc(2);
		chk("src", src, 1'b1);
		hpd = 1'b0;
		cyc(8);
		chk("pd", pd, 1'b1);
		hpd = 1'b1;
		cyc(8);
		chk("pd", pd, 1'b0);
		$display("test strap and hot-plug done");
	endtask
	task t_commit;
		pend = 16'h5a5a;
		rmc_host_model_i.wr(8'h0a, 8'h29);
		cyc(3);
		chk("eqen", eqen, 1'b1);
		chk("act", act, 16'h0000);
		rmc_host_model_i.wr(8'h0a, 8'h2d);
		chk("cmt", cmt, 1'b1);
		cyc(1);
		chk("cmt", cmt, 1'b0);
		chk("eqen", eqen, 1'b0);
		chk("act", act, 16'h5a5a);
		rchk(8'h0a, 8'h29);
		oe = 1'b0;
		pend = 16'h00ff;
		cyc(8);
		chk("act", act, 16'h00ff);
		oe = 1'b1;
		$display("test commit done");
	endtask
	task t_mode;
		rmc_host_model_i.wr(8'h09, 8'hca);
		cyc(2);
		chk("fpd", fpd, 1'b1);
		chk("pd", pd, 1'b1);
		rmc_host_model_i.wr(8'h09, 8'hc2);
		cyc(2);
		chk("pd", pd, 1'b0);
		for (int m = 0; m < 4; m++) begin
			rmc_host_model_i.wr(8'h0a, {6'b001010, m[1:0]});
			cyc(2);
			chk("fm", fm, (m == 0) ? 2'b01 : m[1:0] - 2'b01);
			rmc_host_model_i.toggle_pd(8'hc2);
			cyc(2);
			chk("fm", fm, m[1:0]);
		end
		for (int k = 0; k < 4; k++) begin
			ratio = k[0];
			rmc_host_model_i.wr(8'h0a, {k[1], 7'b0101011});
			cyc(3);
			chk("app", app, k[1]);
			chk("eq", eql, k[1] ? (k[0] ? `RMC_EQ_SNK_R40 : `RMC_EQ_SNK_R10)
				: (k[0] ? `RMC_EQ_SRC_R40 : `RMC_EQ_SRC_R10));
		end
		ratio = 1'b0;
		$display("test mode and equalizer done");
	endtask
	task t_restrap;
		sps = 1'b1;
		rst_n = 1'b0;
		cyc(3);
		rst_n = 1'b1;
		cyc(10);
		rchk(8'h09, 8'hc2);
		rchk(8'h0a, 8'h39);
		$display("test strap reload done");
	endtask
	// main sequence
	initial begin
		cyc(20);
		rst_n = 1'b1;
		cyc(8);
		t_regs;
		t_strap;
		t_commit;
		t_mode;
		t_restrap;
		summarize;
	end
	// hang guard
	initial begin
		#200000;
		errors++;
		$display("BAD timeout exp done got hang");
		summarize;
	end
endmodule // test_retimer_misc_control_regs
`default_nettype wire
